// [logic/gpev_edge.sv]
// Per-pin edge detector for one port.
// Assumes synchronous pin inputs; emits one-cycle event pulses.
module gpev_edge #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    gpev_edge_if.det e
);
    import gpev_pkg::*;

    logic [W-1:0] prev_r;
    logic         primed_r;

    // First sample after reset only primes history, so a pin high at reset is no edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primed_r <= 1'b0;
        end else if (e.ce) begin
            primed_r <= 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_r[i] <= 1'b0;
                end else if (e.ce) begin
                    prev_r[i] <= e.pins[i];
                end
            end
            // Selected edge only; gated by ce so a frozen block sees no edge
            assign e.evt[i] = e.ce & primed_r & (e.falling_sel ? (prev_r[i] & ~e.pins[i])
                                                                : (~prev_r[i] & e.pins[i]));
        end
    endgenerate
endmodule

// [logic/gpev_edge_if.sv]
// Carrier between the register block and its pin edge detector.
// Assumes pins are already synchronous to pclk.
interface gpev_edge_if #(
    parameter int W = 8
);
    logic         ce;
    logic [W-1:0] pins;
    logic         falling_sel;
    logic [W-1:0] evt;

    modport det (input ce, input pins, input falling_sel, output evt);
    modport ctl (output ce, output pins, output falling_sel, input evt);
endinterface

// [logic/gpev_pkg.sv]
// Constants and types for the port input-mode and pin-event flag block.
// Assumes a single pclk domain and an APB master with 32-bit data.
package gpev_pkg;

    typedef logic [11:0] gpev_addr_t;
    typedef logic [31:0] gpev_data_t;
    typedef logic [7:0]  gpev_byte_t;

    // Register indexes; byte address is four times the index
    localparam gpev_byte_t GPEV_IDX_P0_FLAGS = 8'h89;
    localparam gpev_byte_t GPEV_IDX_P1_FLAGS = 8'h8a;
    localparam gpev_byte_t GPEV_IDX_P2_FLAGS = 8'h8b;
    localparam gpev_byte_t GPEV_IDX_EDGE_SEL = 8'h8c;
    localparam gpev_byte_t GPEV_IDX_IRQ_STAT = 8'h90;
    localparam gpev_byte_t GPEV_IDX_IRQ_CLR  = 8'h91;
    localparam gpev_byte_t GPEV_IDX_IRQ_EN   = 8'h92;
    localparam gpev_byte_t GPEV_IDX_P1_MODE  = 8'hf6;
    localparam gpev_byte_t GPEV_IDX_P2_CFG   = 8'hf7;

    // Field positions
    localparam int GPEV_PD2_BIT       = 7;
    localparam int GPEV_PD1_BIT       = 6;
    localparam int GPEV_PD0_BIT       = 5;
    localparam int GPEV_USB_RES_BIT   = 7;
    localparam int GPEV_EDGE_P0_BIT   = 0;
    localparam int GPEV_EDGE_P1_BIT   = 1;
    localparam int GPEV_EDGE_P2_BIT   = 2;
    localparam int GPEV_IRQ_P0_BIT    = 0;
    localparam int GPEV_IRQ_P1_BIT    = 1;
    localparam int GPEV_IRQ_P2_BIT    = 2;
    localparam int GPEV_IRQ_USB_BIT   = 3;

    // Implemented-bit masks
    localparam gpev_byte_t GPEV_P1_MODE_MASK  = 8'hfc;
    localparam gpev_byte_t GPEV_P1_PULL_MASK  = 8'hfc;
    localparam gpev_byte_t GPEV_P2_LOW_MASK   = 8'h1f;
    localparam gpev_byte_t GPEV_P0_USB_MASK   = 8'hbf;
    localparam gpev_byte_t GPEV_P0_PLAIN_MASK = 8'hff;
    localparam gpev_byte_t GPEV_EDGE_MASK     = 8'h07;
    localparam gpev_byte_t GPEV_IRQ_MASK      = 8'h0f;

    // Reset values
    localparam gpev_byte_t GPEV_P_FLAGS_RST  = 8'h00;
    localparam gpev_byte_t GPEV_P1_MODE_RST  = 8'h00;
    localparam gpev_byte_t GPEV_P2_CFG_RST   = 8'h00;
    localparam gpev_byte_t GPEV_EDGE_RST     = 8'h00;
    localparam gpev_byte_t GPEV_IRQ_RST      = 8'h00;

endpackage

// [logic/gpev_top.sv]
// Port input-mode, pull select and pin-event flag registers behind APB.
// Assumes pins and usb_resume_evt are synchronous to pclk; one clock domain.
module gpev_top #(
    parameter bit USB_VARIANT = 1'b0
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire gpev_pkg::gpev_addr_t paddr,
    input  wire gpev_pkg::gpev_data_t pwdata,
    output gpev_pkg::gpev_data_t       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        port0_pins,
    input  wire logic [7:0]        port1_pins,
    input  wire logic [4:0]        port2_pins,
    input  wire logic              usb_resume_evt,
    output logic                   port0_pull_down_sel,
    output logic [7:0]             port1_pull_up_en,
    output logic [7:0]             port1_pull_down_en,
    output logic [4:0]             port2_pull_up_en,
    output logic [4:0]             port2_pull_down_en,
    output logic                   irq
);
    import gpev_pkg::*;

    // Byte addresses derived from the register indexes
    localparam gpev_addr_t A_P0_FLAGS = {2'b00, GPEV_IDX_P0_FLAGS, 2'b00};
    localparam gpev_addr_t A_P1_FLAGS = {2'b00, GPEV_IDX_P1_FLAGS, 2'b00};
    localparam gpev_addr_t A_P2_FLAGS = {2'b00, GPEV_IDX_P2_FLAGS, 2'b00};
    localparam gpev_addr_t A_EDGE_SEL = {2'b00, GPEV_IDX_EDGE_SEL, 2'b00};
    localparam gpev_addr_t A_IRQ_STAT = {2'b00, GPEV_IDX_IRQ_STAT, 2'b00};
    localparam gpev_addr_t A_IRQ_CLR  = {2'b00, GPEV_IDX_IRQ_CLR,  2'b00};
    localparam gpev_addr_t A_IRQ_EN   = {2'b00, GPEV_IDX_IRQ_EN,   2'b00};
    localparam gpev_addr_t A_P1_MODE  = {2'b00, GPEV_IDX_P1_MODE,  2'b00};
    localparam gpev_addr_t A_P2_CFG   = {2'b00, GPEV_IDX_P2_CFG,   2'b00};

    // Port 0 implemented flag bits depend on the variant
    localparam gpev_byte_t P0_MASK = USB_VARIANT ? GPEV_P0_USB_MASK : GPEV_P0_PLAIN_MASK;

    // Configuration and status registers
    gpev_byte_t p1_mode_r;
    gpev_byte_t p2_cfg_r;
    gpev_byte_t p0_flags_r;
    gpev_byte_t p1_flags_r;
    gpev_byte_t p2_flags_r;
    gpev_byte_t edge_sel_r;
    gpev_byte_t irq_stat_r;
    gpev_byte_t irq_en_r;

    gpev_byte_t p1_mode_nxt;
    gpev_byte_t p2_cfg_nxt;
    gpev_byte_t p0_flags_nxt;
    gpev_byte_t p1_flags_nxt;
    gpev_byte_t p2_flags_nxt;
    gpev_byte_t edge_sel_nxt;
    gpev_byte_t irq_stat_nxt;
    gpev_byte_t irq_en_nxt;

    // Bus handshake state
    logic       pready_r;
    logic       pslverr_r;
    gpev_data_t prdata_r;
    logic       irq_r;

    // Decoded access
    logic       setup_cyc;
    logic       wr_acc;
    logic       hit;
    logic       hit_p0;
    logic       hit_p1;
    logic       hit_p2;
    logic       hit_edge;
    logic       hit_stat;
    logic       hit_clr;
    logic       hit_en;
    logic       hit_mode1;
    logic       hit_cfg2;
    gpev_byte_t wbyte;
    gpev_data_t rd_val;

    // Event vectors
    gpev_byte_t set0;
    gpev_byte_t set1;
    gpev_byte_t set2;
    gpev_byte_t irq_set;
    gpev_byte_t clr0;
    gpev_byte_t clr1;
    gpev_byte_t clr2;
    gpev_byte_t irq_clr;

    // Edge detectors, one per port plus the resume line
    gpev_edge_if #(.W(8)) e0 ();
    gpev_edge_if #(.W(8)) e1 ();
    gpev_edge_if #(.W(5)) e2 ();
    gpev_edge_if #(.W(1)) eu ();

    assign e0.ce          = ce;
    assign e0.pins        = port0_pins;
    assign e0.falling_sel = edge_sel_r[GPEV_EDGE_P0_BIT];
    assign e1.ce          = ce;
    assign e1.pins        = port1_pins;
    assign e1.falling_sel = edge_sel_r[GPEV_EDGE_P1_BIT];
    assign e2.ce          = ce;
    assign e2.pins        = port2_pins;
    assign e2.falling_sel = edge_sel_r[GPEV_EDGE_P2_BIT];
    // Resume is always caught on its rising edge, whatever port 0 selects
    assign eu.ce          = ce;
    assign eu.pins        = usb_resume_evt;
    assign eu.falling_sel = 1'b0;

    gpev_edge #(.W(8)) u_edge0 (.pclk(pclk), .presetn(presetn), .e(e0));
    gpev_edge #(.W(8)) u_edge1 (.pclk(pclk), .presetn(presetn), .e(e1));
    gpev_edge #(.W(5)) u_edge2 (.pclk(pclk), .presetn(presetn), .e(e2));
    gpev_edge #(.W(1)) u_edgeu (.pclk(pclk), .presetn(presetn), .e(eu));

    // APB phases; pready answers in the first access cycle
    assign setup_cyc = psel & ~penable & ~pready_r;
    assign wr_acc    = psel & penable & pready_r & pwrite & ce;
    assign wbyte     = pwdata[7:0];

    // Address decode
    always_comb begin
        hit_p0    = 1'b0;
        hit_p1    = 1'b0;
        hit_p2    = 1'b0;
        hit_edge  = 1'b0;
        hit_stat  = 1'b0;
        hit_clr   = 1'b0;
        hit_en    = 1'b0;
        hit_mode1 = 1'b0;
        hit_cfg2  = 1'b0;
        if (paddr == A_P0_FLAGS) begin
            hit_p0 = 1'b1;
        end else if (paddr == A_P1_FLAGS) begin
            hit_p1 = 1'b1;
        end else if (paddr == A_P2_FLAGS) begin
            hit_p2 = 1'b1;
        end else if (paddr == A_EDGE_SEL) begin
            hit_edge = 1'b1;
        end else if (paddr == A_IRQ_STAT) begin
            hit_stat = 1'b1;
        end else if (paddr == A_IRQ_CLR) begin
            hit_clr = 1'b1;
        end else if (paddr == A_IRQ_EN) begin
            hit_en = 1'b1;
        end else if (paddr == A_P1_MODE) begin
            hit_mode1 = 1'b1;
        end else if (paddr == A_P2_CFG) begin
            hit_cfg2 = 1'b1;
        end
    end

    assign hit = hit_p0 | hit_p1 | hit_p2 | hit_edge | hit_stat | hit_clr
               | hit_en | hit_mode1 | hit_cfg2;

    // Read mux; unimplemented bits and the clear register read zero
    always_comb begin
        rd_val = '0;
        if (hit_p0) begin
            rd_val[7:0] = p0_flags_r;
        end else if (hit_p1) begin
            rd_val[7:0] = p1_flags_r;
        end else if (hit_p2) begin
            rd_val[7:0] = p2_flags_r & GPEV_P2_LOW_MASK;
        end else if (hit_edge) begin
            rd_val[7:0] = edge_sel_r;
        end else if (hit_stat) begin
            rd_val[7:0] = irq_stat_r;
        end else if (hit_en) begin
            rd_val[7:0] = irq_en_r;
        end else if (hit_mode1) begin
            rd_val[7:0] = p1_mode_r & GPEV_P1_MODE_MASK;
        end else if (hit_cfg2) begin
            rd_val[7:0] = p2_cfg_r;
        end
    end

    // Bus answer: one wait-free access phase; unmapped addresses report pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else if (ce) begin
            pready_r  <= setup_cyc;
            pslverr_r <= setup_cyc & ~hit;
            if (setup_cyc && !pwrite) begin
                prdata_r <= rd_val;
            end
        end
    end

    // Per-port set vectors; on the USB variant bit 6 never sets and bit 7 is resume
    always_comb begin
        if (USB_VARIANT) begin
            set0 = {eu.evt[0], 1'b0, e0.evt[5:0]};
        end else begin
            set0 = e0.evt;
        end
        set1 = e1.evt;
        set2 = {3'b000, e2.evt};
    end

    // Write of zero clears a flag, write of one keeps it
    always_comb begin
        clr0 = (wr_acc && hit_p0) ? ~wbyte : 8'h00;
        clr1 = (wr_acc && hit_p1) ? ~wbyte : 8'h00;
        clr2 = (wr_acc && hit_p2) ? ~wbyte : 8'h00;
    end

    // A new edge in the clearing cycle wins, so no event is lost
    assign p0_flags_nxt = ((p0_flags_r & ~clr0) | set0) & P0_MASK;
    assign p1_flags_nxt = (p1_flags_r & ~clr1) | set1;
    assign p2_flags_nxt = ((p2_flags_r & ~clr2) | set2) & GPEV_P2_LOW_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p0_flags_r <= GPEV_P_FLAGS_RST;
            p1_flags_r <= GPEV_P_FLAGS_RST;
            p2_flags_r <= GPEV_P_FLAGS_RST;
        end else if (ce) begin
            p0_flags_r <= p0_flags_nxt;
            p1_flags_r <= p1_flags_nxt;
            p2_flags_r <= p2_flags_nxt;
        end
    end

    // Input modes and pull selects
    always_comb begin
        p1_mode_nxt  = p1_mode_r;
        p2_cfg_nxt   = p2_cfg_r;
        edge_sel_nxt = edge_sel_r;
        if (wr_acc && hit_mode1) begin
            p1_mode_nxt = wbyte & GPEV_P1_MODE_MASK;
        end
        if (wr_acc && hit_cfg2) begin
            p2_cfg_nxt = wbyte;
        end
        if (wr_acc && hit_edge) begin
            edge_sel_nxt = wbyte & GPEV_EDGE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p1_mode_r  <= GPEV_P1_MODE_RST;
            p2_cfg_r   <= GPEV_P2_CFG_RST;
            edge_sel_r <= GPEV_EDGE_RST;
        end else if (ce) begin
            p1_mode_r  <= p1_mode_nxt;
            p2_cfg_r   <= p2_cfg_nxt;
            edge_sel_r <= edge_sel_nxt;
        end
    end

    // Interrupt status: any pin event of a port sets that port's sticky bit, except port 0 pins 6 and 7 on the USB variant
    always_comb begin
        irq_set = 8'h00;
        irq_set[GPEV_IRQ_P0_BIT]  = |(set0 & ~(8'h01 << GPEV_USB_RES_BIT)) | (~USB_VARIANT & set0[GPEV_USB_RES_BIT]);
        irq_set[GPEV_IRQ_P1_BIT]  = |set1;
        irq_set[GPEV_IRQ_P2_BIT]  = |set2;
        irq_set[GPEV_IRQ_USB_BIT] = USB_VARIANT & set0[GPEV_USB_RES_BIT];
        irq_clr = (wr_acc && hit_clr) ? wbyte : 8'h00;
        irq_en_nxt = (wr_acc && hit_en) ? (wbyte & GPEV_IRQ_MASK) : irq_en_r;
    end

    // Set beats clear here as well
    assign irq_stat_nxt = ((irq_stat_r & ~irq_clr) | irq_set) & GPEV_IRQ_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= GPEV_IRQ_RST;
            irq_en_r   <= GPEV_IRQ_RST;
        end else if (ce) begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r   <= irq_en_nxt;
        end
    end

    // Level interrupt, one cycle behind status so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(irq_stat_r & irq_en_r);
        end
    end

    // Pad controls registered; tristate pins get neither pull
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port0_pull_down_sel <= 1'b0;
            port1_pull_up_en    <= 8'h00;
            port1_pull_down_en  <= 8'h00;
            port2_pull_up_en    <= 5'h00;
            port2_pull_down_en  <= 5'h00;
        end else if (ce) begin
            port0_pull_down_sel <= p2_cfg_r[GPEV_PD0_BIT];
            // Pins 0 and 1 of port 1 have no pull, masked off
            port1_pull_up_en   <= ~p1_mode_r & GPEV_P1_PULL_MASK
                                  & {8{~p2_cfg_r[GPEV_PD1_BIT]}};
            port1_pull_down_en <= ~p1_mode_r & GPEV_P1_PULL_MASK
                                  & {8{p2_cfg_r[GPEV_PD1_BIT]}};
            port2_pull_up_en   <= ~p2_cfg_r[4:0] & {5{~p2_cfg_r[GPEV_PD2_BIT]}};
            port2_pull_down_en <= ~p2_cfg_r[4:0] & {5{p2_cfg_r[GPEV_PD2_BIT]}};
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;
endmodule

// [testbench/gpev_checker.sv]
// Concurrent checks on the port pin-event block, bound to gpev_top.
// Assumes one pclk domain; ce held high outside reset by the bench.
module gpev_checker
    import gpev_pkg::*;
#(
    parameter bit USB_VARIANT = 1'b0
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire gpev_addr_t paddr,
    input wire gpev_data_t pwdata,
    input wire gpev_data_t prdata,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       port0_pull_down_sel,
    input wire logic [7:0] port1_pull_up_en,
    input wire logic [7:0] port1_pull_down_en,
    input wire logic [4:0] port2_pull_up_en,
    input wire logic [4:0] port2_pull_down_en,
    input wire logic       irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);
    // Completed transfers, split by kind and target
    logic done_rd;
    logic wr_cfg;
    logic wr_en0;
    assign done_rd = psel && penable && pready && !pwrite;
    assign wr_cfg  = psel && penable && pready && pwrite && paddr == 12'h3dc && !pslverr;
    assign wr_en0  = psel && penable && pready && pwrite && paddr == 12'h248
                     && pwdata[3:0] == 4'h0;

    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rd_upper: assert property (done_rd |-> prdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    chk_p1_mode_low: assert property (done_rd && paddr == 12'h3d8 |-> prdata[1:0] == 2'b00)
        else $error("port 1 mode low bits not zero");
    chk_p2_flag_hi: assert property (done_rd && paddr == 12'h22c |-> prdata[7:5] == 3'b000)
        else $error("port 2 flag upper bits not zero");
    chk_p1_no_pull: assert property ((port1_pull_up_en[1:0] | port1_pull_down_en[1:0]) == 2'b00)
        else $error("port 1 pins 1:0 pulled");
    chk_p1_one_dir: assert property (|port1_pull_up_en |-> port1_pull_down_en == 8'h00)
        else $error("port 1 pulled both ways");
    chk_p2_one_dir: assert property (|port2_pull_up_en |-> port2_pull_down_en == 5'h00)
        else $error("port 2 pulled both ways");
    chk_p2_follow: assert property (wr_cfg |=> ##1 port2_pull_down_en ==
        ($past(pwdata[7], 2) ? ~$past(pwdata[4:0], 2) : 5'h00))
        else $error("port 2 pull-down enables wrong after write");
    chk_p0_follow: assert property (wr_cfg |=> ##1 port0_pull_down_sel == $past(pwdata[5], 2))
        else $error("port 0 pull select wrong after write");
    chk_irq_masked: assert property (wr_en0 |=> ##1 !irq)
        else $error("irq high with all enables off");
    chk_reset_quiet: assert property (disable iff (1'b0) !presetn |-> !irq && !pready)
        else $error("outputs active in reset");
endmodule

bind gpev_top gpev_checker #(.USB_VARIANT(USB_VARIANT)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port0_pull_down_sel(port0_pull_down_sel),
    .port1_pull_up_en(port1_pull_up_en), .port1_pull_down_en(port1_pull_down_en),
    .port2_pull_up_en(port2_pull_up_en), .port2_pull_down_en(port2_pull_down_en), .irq(irq)
);

// [testbench/gpev_pin_model.sv]
// Off-chip circuitry on one port: drives pins or leaves them to the pads.
// Assumes pull enables come from the block; drive is set by the bench.
module gpev_pin_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pull_up_en,
    input  wire logic [W-1:0] pull_down_en,
    input  wire logic         pclk,
    output logic      [W-1:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] drv_en = '1;
    logic [W-1:0] drv    = '0;
    initial pins = '0;
    // A released unpulled pin floats; showing the inverse keeps it from looking stable
    always @(posedge pclk) begin
        for (int i = 0; i < W; i++) begin
            if (drv_en[i]) pins[i] <= drv[i];
            else if (pull_up_en[i]) pins[i] <= 1'b1;
            else if (pull_down_en[i]) pins[i] <= 1'b0;
            else pins[i] <= ~pins[i];
        end
    end
endmodule

// [testbench/gpev_tb_top.sv]
// Self-checking bench for gpev_top: APB driver, pin models, read scoreboard.
// Assumes the non-USB build; ce and the resume line are held constant.
module gpev_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gpev_pkg::*;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    gpev_addr_t  paddr = '0;
    gpev_data_t  pwdata = '0, prdata;
    logic        pready, pslverr, irq, p0_pd;
    logic [7:0]  p0_pins, p1_pins, p1_up, p1_dn;
    logic [4:0]  p2_pins, p2_up, p2_dn;
    logic [32:0] expq[$];
    logic [32:0] me;
    int          fails = 0, comparisons = 0;
    gpev_addr_t  fa[3] = '{12'h224, 12'h228, 12'h22c};
    gpev_addr_t  ra[9] = '{12'h224, 12'h228, 12'h22c, 12'h230, 12'h240, 12'h244,
                           12'h248, 12'h3d8, 12'h3dc};

    gpev_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port0_pins(p0_pins), .port1_pins(p1_pins), .port2_pins(p2_pins),
        .usb_resume_evt(1'b0), .port0_pull_down_sel(p0_pd), .port1_pull_up_en(p1_up),
        .port1_pull_down_en(p1_dn), .port2_pull_up_en(p2_up), .port2_pull_down_en(p2_dn),
        .irq(irq));
    gpev_pin_model #(.W(8)) m0 (.pclk(pclk), .pull_up_en({8{~p0_pd}}),
        .pull_down_en({8{p0_pd}}), .pins(p0_pins));
    gpev_pin_model #(.W(8)) m1 (.pclk(pclk), .pull_up_en(p1_up), .pull_down_en(p1_dn),
        .pins(p1_pins));
    gpev_pin_model #(.W(5)) m2 (.pclk(pclk), .pull_up_en(p2_up), .pull_down_en(p2_dn),
        .pins(p2_pins));

    // 25 MHz clock
    initial begin
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        comparisons++;
        if (got !== ex) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask

    // One transfer, then an idle cycle so no signal is assigned twice in a step
    task automatic apb(input logic w, input gpev_addr_t a, input logic [7:0] d,
                       input logic [32:0] e);
        int n;
        expq.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input gpev_addr_t a, input logic [7:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input gpev_addr_t a, input logic [7:0] d);
        apb(1'b0, a, d, {25'h0, d});
    endtask

    task automatic drive(input int p, input logic [7:0] v);
        case (p)
            0: m0.drv <= v;
            1: m1.drv <= v;
            default: m2.drv <= v[4:0];
        endcase
        repeat (3) @(posedge pclk);
    endtask

    // Scoreboard: oldest note against each answer seen at its sampling edge
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            me = expq.pop_front();
            chk("pslverr", {7'h0, me[32]}, {7'h0, pslverr});
            if (!pwrite) chk("prdata", me[7:0], (prdata[31:8] === 24'h0) ? prdata[7:0] : 8'hxx);
        end
    end

    initial begin
        logic [7:0] v, c, m;
        void'($urandom(79892));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) rd(ra[i], 8'h00);
        apb(1'b0, 12'h000, 8'h00, 33'h1_0000_0000);
        apb(1'b1, 12'h004, 8'hff, 33'h1_0000_0000);
        // Mode and pull select words, with the pad enables they produce
        for (int k = 0; k < 4; k++) begin
            m = $urandom;
            c = $urandom;
            wr(12'h3d8, m);
            wr(12'h3dc, c);
            rd(12'h3d8, m & 8'hfc);
            rd(12'h3dc, c);
            chk("p1_up", ~m & 8'hfc & {8{~c[6]}}, p1_up);
            chk("p1_dn", ~m & 8'hfc & {8{c[6]}}, p1_dn);
            chk("p2_up", {3'h0, ~c[4:0] & {5{~c[7]}}}, {3'h0, p2_up});
            chk("p2_dn", {3'h0, ~c[4:0] & {5{c[7]}}}, {3'h0, p2_dn});
            chk("p0_pd", {7'h0, c[5]}, {7'h0, p0_pd});
        end
        wr(12'h3dc, 8'h00);
        wr(12'h3d8, 8'h00);
        wr(12'h248, 8'h07);
        // Rising then falling events per port, with partial clears between
        for (int p = 0; p < 3; p++) begin
            v = $urandom | 8'h01;
            if (p == 2) v[7:5] = 3'h0;
            drive(p, v);
            rd(fa[p], v);
            c = $urandom;
            wr(fa[p], c);
            rd(fa[p], v & c);
            wr(12'h230, 8'h01 << p);
            drive(p, 8'h00);
            rd(fa[p], v);
            wr(fa[p], 8'h00);
            rd(fa[p], 8'h00);
            wr(12'h230, 8'h00);
        end
        rd(12'h240, 8'h07);
        chk("irq_on", 8'h01, {7'h0, irq});
        // irq leaves its flop one edge after the enable or status flop; read it a cycle later
        wr(12'h248, 8'h00);
        @(posedge pclk);
        chk("irq_mask", 8'h00, {7'h0, irq});
        wr(12'h248, 8'h07);
        @(posedge pclk);
        chk("irq_unmask", 8'h01, {7'h0, irq});
        wr(12'h240, 8'h00);
        wr(12'h244, 8'h0f);
        @(posedge pclk);
        chk("irq_clr", 8'h00, {7'h0, irq});
        rd(12'h240, 8'h00);
        rd(12'h244, 8'h00);
        // Released port 2 pins rise under pull-up, then fall under pull-down
        m2.drv_en <= '0;
        repeat (3) @(posedge pclk);
        rd(12'h22c, 8'h1f);
        wr(12'h22c, 8'h00);
        wr(12'h3dc, 8'h80);
        repeat (3) @(posedge pclk);
        rd(12'h22c, 8'h00);
        chk("p2_pins", 8'h00, {3'h0, p2_pins});
        stop_test();
    end
endmodule
